// [logic/dcfc_top.sv]
// Dual clock buffer control with flags, offsets and an AHB-Lite status window
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module dcfc_top import dcfc_pkg::*; (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          write_clk,
  input  wire logic          read_clk,
  input  wire logic          write_enable_n,
  input  wire logic          read_enable_n,
  input  wire logic          full_reset_n,
  input  wire logic          partial_reset_n,
  input  wire logic          retransmit_n,
  input  wire logic          mode_select_serial_in,
  input  wire logic          serial_load_enable_n,
  input  wire logic          offset_access_n,
  input  wire logic          output_enable_n,
  input  wire logic          tied_static_pin,
  input  wire logic [DW-1:0] write_data,
  output logic      [DW-1:0] read_data,
  output logic               read_data_oe,
  output logic               full_or_input_ready,
  output logic               empty_or_output_ready,
  output logic               almost_full_n,
  output logic               almost_empty_n,
  output logic               half_full_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  dcfc_pins_s  p_in;
  dcfc_pins_s  p_meta_q;
  dcfc_pins_s  p_q;
  dcfc_pins_s  p_prev_q;
  logic        wr_rise;
  logic        rd_rise;
  logic        rd_tog;

  assign p_in = '{write_clk: write_clk, read_clk: read_clk, write_enable_n: write_enable_n,
                  read_enable_n: read_enable_n, full_reset_n: full_reset_n,
                  partial_reset_n: partial_reset_n, retransmit_n: retransmit_n,
                  mode_select_serial_in: mode_select_serial_in,
                  serial_load_enable_n: serial_load_enable_n, offset_access_n: offset_access_n,
                  output_enable_n: output_enable_n, write_data: write_data};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_meta_q <= PINS_RST;
      p_q      <= PINS_RST;
      p_prev_q <= PINS_RST;
    end else begin
      p_meta_q <= p_in;
      p_q      <= p_meta_q;
      p_prev_q <= p_q;
    end
  end

  assign wr_rise = p_q.write_clk & ~p_prev_q.write_clk;
  assign rd_rise = p_q.read_clk & ~p_prev_q.read_clk;
  assign rd_tog  = p_q.read_clk ^ p_prev_q.read_clk;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [DEPTH];
  logic          mem_we;
  logic [DW-1:0] mem_rd;
  logic [14:0]   wptr_q, wptr_d, rptr_q, rptr_d;
  logic [14:0]   count;
  logic          empty;
  logic          full;

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[wptr_q[AW-1:0]] <= p_q.write_data;
    end
  end

  assign mem_rd = mem[rptr_q[AW-1:0]];
  assign count  = wptr_q - rptr_q;
  assign empty  = (count == 15'h0000);
  assign full   = (count == DEPTH_WORDS);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  dcfc_cfg_s     cfg_q, cfg_d;
  logic [13:0]   eoff_q, eoff_d, foff_q, foff_d;
  logic [1:0]    widx_q, widx_d, ridx_q, ridx_d, ftc_q, ftc_d;
  logic [DW-1:0] dout_q, dout_d;
  logic          or_q, or_d, rtb_q, rtb_d;
  logic          en_q, en_d, prs_sw_q, prs_sw_d;
  logic [DW-1:0] off_word;
  logic [27:0]   chain;

  always_comb begin
    case (ridx_q)
      2'h0:    off_word = eoff_q[8:0];
      2'h1:    off_word = {4'h0, eoff_q[13:9]};
      2'h2:    off_word = foff_q[8:0];
      default: off_word = {4'h0, foff_q[13:9]};
    endcase
  end

  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cfg_d  = cfg_q;
    eoff_d = eoff_q;
    foff_d = foff_q;
    widx_d = widx_q;
    ridx_d = ridx_q;
    ftc_d  = ftc_q;
    dout_d = dout_q;
    or_d   = or_q;
    rtb_d  = rtb_q;
    mem_we = 1'b0;
    chain  = {p_q.mode_select_serial_in, foff_q, eoff_q[13:1]};
    if (!p_q.full_reset_n) begin
      wptr_d = 15'h0000;
      rptr_d = 15'h0000;
      dout_d = 9'h000;
      cfg_d.fall_through_mode = p_q.mode_select_serial_in;
      cfg_d.serial_load       = p_q.offset_access_n;
      eoff_d = p_q.offset_access_n ? OFF_LONG : OFF_SHORT;
      foff_d = p_q.offset_access_n ? OFF_LONG : OFF_SHORT;
      widx_d = 2'h0;
      ridx_d = 2'h0;
      ftc_d  = 2'h0;
      or_d   = 1'b0;
      rtb_d  = 1'b0;
    end else if (!p_q.partial_reset_n || prs_sw_q) begin
      wptr_d = 15'h0000;
      rptr_d = 15'h0000;
      dout_d = 9'h000;
      widx_d = 2'h0;
      ridx_d = 2'h0;
      ftc_d  = 2'h0;
      or_d   = 1'b0;
      rtb_d  = 1'b0;
    end else if (en_q) begin
      if (wr_rise) begin
        if (!p_q.offset_access_n && !p_q.serial_load_enable_n && cfg_q.serial_load) begin
          {foff_d, eoff_d} = chain;
        end else if (!p_q.offset_access_n && !p_q.write_enable_n) begin
          if (!cfg_q.serial_load) begin
            case (widx_q)
              2'h0:    eoff_d[8:0]  = p_q.write_data;
              2'h1:    eoff_d[13:9] = p_q.write_data[4:0];
              2'h2:    foff_d[8:0]  = p_q.write_data;
              default: foff_d[13:9] = p_q.write_data[4:0];
            endcase
            widx_d = widx_q + 2'h1;
          end
        end else if (!p_q.write_enable_n && !full) begin
          mem_we = 1'b1;
          wptr_d = wptr_q + 15'h0001;
        end
      end
      if (cfg_q.fall_through_mode && !or_q && !empty && rd_tog) begin
        if (ftc_q == FT_TRANS - 2'h1) begin
          dout_d = mem_rd;
          rptr_d = rptr_q + 15'h0001;
          or_d   = 1'b1;
          ftc_d  = 2'h0;
        end else begin
          ftc_d  = ftc_q + 2'h1;
        end
      end else if (empty && !or_q) begin
        ftc_d = 2'h0;
      end
      if (rd_rise) begin
        rtb_d = 1'b0;
        if (!p_q.retransmit_n) begin
          rptr_d = 15'h0000;
          rtb_d  = 1'b1;
          or_d   = 1'b0;
          ftc_d  = 2'h0;
        end else if (!p_q.read_enable_n && !p_q.offset_access_n) begin
          dout_d = off_word;
          ridx_d = ridx_q + 2'h1;
        end else if (!p_q.read_enable_n && !cfg_q.fall_through_mode) begin
          if (!empty) begin
            dout_d = mem_rd;
            rptr_d = rptr_q + 15'h0001;
          end
        end else if (!p_q.read_enable_n && or_q) begin
          if (!empty) begin
            dout_d = mem_rd;
            rptr_d = rptr_q + 15'h0001;
          end else begin
            or_d   = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr_q <= 15'h0000;
      rptr_q <= 15'h0000;
      cfg_q  <= '0;
      eoff_q <= OFF_SHORT;
      foff_q <= OFF_SHORT;
      widx_q <= 2'h0;
      ridx_q <= 2'h0;
      ftc_q  <= 2'h0;
      dout_q <= 9'h000;
      or_q   <= 1'b0;
      rtb_q  <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cfg_q  <= cfg_d;
      eoff_q <= eoff_d;
      foff_q <= foff_d;
      widx_q <= widx_d;
      ridx_q <= ridx_d;
      ftc_q  <= ftc_d;
      dout_q <= dout_d;
      or_q   <= or_d;
      rtb_q  <= rtb_d;
    end
  end

  // ----------------------------------------------------------------
  // Flag and output pins
  // ----------------------------------------------------------------
  logic [6:0] flg_d, flg_q;

  always_comb begin
    flg_d[0] = cfg_q.fall_through_mode ? full : ~full;
    flg_d[1] = cfg_q.fall_through_mode ? ~or_q : ~(empty | rtb_q);
    flg_d[2] = ~(count > (DEPTH_WORDS - {1'b0, foff_q}));
    flg_d[3] = ~(count < {1'b0, eoff_q});
    flg_d[4] = ~(count > HALF_WORDS);
    flg_d[5] = ~p_q.output_enable_n;
    flg_d[6] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flg_q <= 7'h1f;
    end else begin
      flg_q <= flg_d;
    end
  end

  assign full_or_input_ready   = flg_q[0];
  assign empty_or_output_ready = flg_q[1];
  assign almost_full_n         = flg_q[2];
  assign almost_empty_n        = flg_q[3];
  assign half_full_n           = flg_q[4];
  assign read_data_oe          = flg_q[5];
  assign read_data             = dout_q;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        wph_q, wph_d;
  logic [3:0]  wadr_q, wadr_d;
  logic [31:0] rdat_q, rdat_d;
  logic        aph;

  assign aph = hsel & htrans[1] & hready;

  always_comb begin
    wph_d    = aph & hwrite;
    wadr_d   = haddr[3:0];
    rdat_d   = rdat_q;
    en_d     = en_q;
    prs_sw_d = 1'b0;
    if (aph && !hwrite) begin
      case (haddr[3:0])
        A_CTRL:  rdat_d = {31'h00000000, en_q};
        A_STAT:  rdat_d = {12'h000, cfg_q.serial_load, cfg_q.fall_through_mode, empty, full, 1'b0, count};
        A_OFFS:  rdat_d = {2'h0, foff_q, 2'h0, eoff_q};
        default: rdat_d = 32'h00000000;
      endcase
    end
    if (wph_q && wadr_q == A_CTRL) begin
      en_d     = hwdata[CTRL_EN];
      prs_sw_d = hwdata[CTRL_PRS];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q    <= 1'b0;
      wadr_q   <= 4'h0;
      rdat_q   <= 32'h00000000;
      en_q     <= CTRL_EN_RST;
      prs_sw_q <= 1'b0;
    end else begin
      wph_q    <= wph_d;
      wadr_q   <= wadr_d;
      rdat_q   <= rdat_d;
      en_q     <= en_d;
      prs_sw_q <= prs_sw_d;
    end
  end

  assign hrdata    = rdat_q;
  assign hreadyout = flg_q[6] | 1'b1;
  assign hresp     = flg_q[6];

endmodule

// [logic/dcfc_pkg.sv]
// Constants, types and field layout for the dual clock buffer control block
package dcfc_pkg;

  localparam int          DW          = 9;
  localparam int          AW          = 14;
  localparam int          DEPTH       = 16384;
  localparam logic [14:0] DEPTH_WORDS = 15'h4000;
  localparam logic [14:0] HALF_WORDS  = 15'h2000;
  localparam logic [13:0] OFF_SHORT   = 14'h007f;
  localparam logic [13:0] OFF_LONG    = 14'h03ff;
  localparam logic [1:0]  FT_TRANS    = 2'h3;

  // Register byte offsets within the slave window, control bit positions and enable reset value
  localparam logic [3:0]  A_CTRL      = 4'h0;
  localparam logic [3:0]  A_STAT      = 4'h4;
  localparam logic [3:0]  A_OFFS      = 4'h8;
  localparam int          CTRL_EN     = 0;
  localparam int          CTRL_PRS    = 1;
  localparam logic        CTRL_EN_RST = 1'b1;

  typedef struct packed {
    logic          write_clk;
    logic          read_clk;
    logic          write_enable_n;
    logic          read_enable_n;
    logic          full_reset_n;
    logic          partial_reset_n;
    logic          retransmit_n;
    logic          mode_select_serial_in;
    logic          serial_load_enable_n;
    logic          offset_access_n;
    logic          output_enable_n;
    logic [DW-1:0] write_data;
  } dcfc_pins_s;

  localparam dcfc_pins_s PINS_RST = '{default: 1'b1, write_clk: 1'b0, read_clk: 1'b0, write_data: 9'h000};

  typedef struct packed {
    logic fall_through_mode;
    logic serial_load;
  } dcfc_cfg_s;

endpackage

// [dv/dcfc_monitor.sv]
// Port checks for the dual clock buffer control
`timescale 1ns/1ps
module dcfc_monitor import dcfc_pkg::*; (
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hsel,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic          write_clk,
  input wire logic          read_clk,
  input wire logic          full_reset_n,
  input wire logic          partial_reset_n,
  input wire logic          output_enable_n,
  input wire logic [DW-1:0] read_data,
  input wire logic          read_data_oe,
  input wire logic          almost_full_n,
  input wire logic          almost_empty_n,
  input wire logic          half_full_n
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------
  // Checks
  // ----------
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_FRST_OUT: assert property (!full_reset_n [*6] |-> read_data == 9'h000)
    else $error("full reset left output word");
  AST_FRST_FLAGS: assert property (!full_reset_n [*7] |-> !almost_empty_n && almost_full_n && half_full_n)
    else $error("flags wrong in full reset");
  AST_PRST_OUT: assert property (!partial_reset_n [*6] |-> read_data == 9'h000 && half_full_n)
    else $error("partial reset left output word");
  AST_OE_ON: assert property (!output_enable_n [*5] |-> read_data_oe)
    else $error("output bus not driven");
  AST_OE_OFF: assert property (output_enable_n [*5] |-> !read_data_oe)
    else $error("output bus not floated");
  AST_FLAG_HOLD: assert property ((!write_clk && !read_clk && !hsel && full_reset_n && partial_reset_n) [*8]
    |-> $stable(half_full_n) && $stable(almost_full_n) && $stable(almost_empty_n))
    else $error("flag moved without pin activity");
  AST_DATA_HOLD: assert property ((!read_clk && !hsel && full_reset_n && partial_reset_n) [*8]
    |-> $stable(read_data))
    else $error("output word moved without read edge");
endmodule

bind dcfc_top dcfc_monitor mon_u (
  .hclk, .hresetn, .hsel, .hreadyout, .hresp, .write_clk, .read_clk, .full_reset_n, .partial_reset_n,
  .output_enable_n, .read_data, .read_data_oe, .almost_full_n, .almost_empty_n, .half_full_n
);

// [dv/dcfc_partner.sv]
// Writer and reader pin model facing the buffer ports
`timescale 1ns/1ps
module dcfc_partner import dcfc_pkg::*; (
  input  wire logic hclk,
  output dcfc_pins_s p
);
  initial p = PINS_RST;
  task automatic w(int n);
    repeat (n) @(posedge hclk);
  endtask
  // Pin clock pulse; controls stand 3 cycles either side
  task automatic pulse(bit rd);
    w(3);
    if (rd) p.read_clk <= 1'b1;
    else p.write_clk <= 1'b1;
    w(3);
    if (rd) p.read_clk <= 1'b0;
    else p.write_clk <= 1'b0;
    w(3);
  endtask
  task automatic wr(logic [DW-1:0] d);
    @(posedge hclk);
    p.write_enable_n <= 1'b0;
    p.write_data <= d;
    pulse(1'b0);
    p.write_enable_n <= 1'b1;
    p.write_data <= ~d;
  endtask
  // Read, or retransmit when rt is set
  task automatic rd(bit rt);
    @(posedge hclk);
    if (rt) p.retransmit_n <= 1'b0;
    else p.read_enable_n <= 1'b0;
    pulse(1'b1);
    p.retransmit_n <= 1'b1;
    p.read_enable_n <= 1'b1;
  endtask
  task automatic ld(bit v);
    @(posedge hclk);
    p.offset_access_n <= v;
  endtask
  task automatic oe(bit v);
    p.output_enable_n <= v;
  endtask
  task automatic sh(bit b);
    @(posedge hclk);
    p.serial_load_enable_n <= 1'b0;
    p.offset_access_n <= 1'b0;
    p.mode_select_serial_in <= b;
    pulse(1'b0);
    p.serial_load_enable_n <= 1'b1;
    p.offset_access_n <= 1'b1;
  endtask
  task automatic tog;
    @(posedge hclk);
    p.read_clk <= ~p.read_clk;
    w(2);
  endtask
  task automatic frst(bit ft, bit lv);
    @(posedge hclk);
    p.full_reset_n <= 1'b0;
    p.mode_select_serial_in <= ft;
    p.offset_access_n <= lv;
    w(8);
    p.full_reset_n <= 1'b1;
    w(4);
    p.offset_access_n <= 1'b1;
  endtask
  task automatic prst;
    @(posedge hclk);
    p.partial_reset_n <= 1'b0;
    w(8);
    p.partial_reset_n <= 1'b1;
    w(4);
  endtask
endmodule

// [dv/tb_dual_clock_fifo_control.sv]
// Self-checking bench for the dual clock buffer control
`timescale 1ns/1ps
`define CHK(s, e, a) begin checks_done++; if ((a) !== (e)) begin n_errors++; $display("wrong value %s exp %h got %h", s, e, a); end end
module tb_dual_clock_fifo_control import dcfc_pkg::*;;
  typedef struct packed {logic [8:0] d; logic [14:0] c;} dcfc_row_s;
  localparam dcfc_row_s ROWS [4] = '{'{9'h1ff, 15'h1}, '{9'h000, 15'h2}, '{9'h155, 15'h3}, '{9'h0aa, 15'h4}};
  localparam logic [27:0] SER = 28'h0008003;
  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [2:0]    hsize = 3'h0;
  logic [31:0]   hwdata = 32'h0;
  logic [31:0]   hrdata, r;
  logic          hreadyout, hresp, read_data_oe, full_or_input_ready, empty_or_output_ready;
  logic          almost_full_n, almost_empty_n, half_full_n;
  logic [DW-1:0] read_data;
  wire dcfc_pins_s p;
  int            n_errors = 0;
  int            checks_done = 0;
  int            cyc = 0;
  always #20 hclk = ~hclk;
  dcfc_partner pm (.hclk, .p);
  dcfc_top dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .write_clk(p.write_clk), .read_clk(p.read_clk), .write_enable_n(p.write_enable_n),
    .read_enable_n(p.read_enable_n), .full_reset_n(p.full_reset_n), .partial_reset_n(p.partial_reset_n),
    .retransmit_n(p.retransmit_n), .mode_select_serial_in(p.mode_select_serial_in),
    .serial_load_enable_n(p.serial_load_enable_n), .offset_access_n(p.offset_access_n),
    .output_enable_n(p.output_enable_n), .tied_static_pin(1'b0), .write_data(p.write_data), .read_data,
    .read_data_oe, .full_or_input_ready, .empty_or_output_ready, .almost_full_n, .almost_empty_n, .half_full_n);
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      test_done;
    end
  end
  // One single word transfer; waits for the slave answer
  task automatic ahb(logic wr, logic [3:0] a, logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rchk(string s, logic [3:0] a, logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(s, e, r)
  endtask
  function automatic logic [31:0] st(logic [14:0] c, logic ft, logic sl);
    return {12'h000, sl, ft, c == 15'h0000, c == DEPTH_WORDS, 1'b0, c};
  endfunction
  task automatic tend(string s);
    $display("test %s done", s);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    pm.frst(1'b0, 1'b0);
    pm.oe(1'b0);
    rchk("offsets", A_OFFS, 32'h007f007f);
    rchk("unmapped", 4'hc, 32'h0);
    ahb(1'b1, A_CTRL, 32'h0);
    pm.wr(9'h033);
    rchk("disabled", A_STAT, st(15'h0, 1'b0, 1'b0));
    ahb(1'b1, A_CTRL, 32'h1);
    rchk("ctrl", A_CTRL, 32'h1);
    `CHK("empty", 1'b0, empty_or_output_ready)
    `CHK("full", 1'b1, full_or_input_ready)
    `CHK("oe", 1'b1, read_data_oe)
    tend("reset");
    for (int i = 0; i < 4; i++) begin
      pm.wr(ROWS[i].d);
      rchk("count", A_STAT, st(ROWS[i].c, 1'b0, 1'b0));
    end
    for (int i = 0; i < 4; i++) begin
      pm.rd(1'b0);
      `CHK("word", ROWS[i].d, read_data)
    end
    tend("rows");
    pm.rd(1'b0);
    rchk("empty read", A_STAT, st(15'h0, 1'b0, 1'b0));
    `CHK("held word", 9'h0aa, read_data)
    tend("empty read");
    pm.wr(9'h101);
    pm.wr(9'h102);
    pm.rd(1'b0);
    pm.rd(1'b0);
    pm.rd(1'b1);
    `CHK("rt empty", 1'b0, empty_or_output_ready)
    pm.rd(1'b0);
    `CHK("rt word", 9'h1ff, read_data)
    rchk("rt count", A_STAT, st(15'h5, 1'b0, 1'b0));
    ahb(1'b1, A_CTRL, 32'h3);
    rchk("sw prs count", A_STAT, st(15'h0, 1'b0, 1'b0));
    `CHK("sw prs word", 9'h000, read_data)
    tend("retransmit");
    pm.ld(1'b0);
    pm.wr(9'h005);
    pm.wr(9'h000);
    pm.wr(9'h00a);
    pm.wr(9'h000);
    rchk("par offsets", A_OFFS, 32'h000a0005);
    pm.rd(1'b0);
    `CHK("offset read", 9'h005, read_data)
    pm.ld(1'b1);
    pm.prst;
    rchk("prs offsets", A_OFFS, 32'h000a0005);
    rchk("prs count", A_STAT, st(15'h0, 1'b0, 1'b0));
    for (int i = 0; i < 5; i++) begin
      `CHK("almost empty", 1'b0, almost_empty_n)
      pm.wr(9'h0f0);
    end
    `CHK("above n", 1'b1, almost_empty_n)
    `CHK("almost full", 1'b1, almost_full_n)
    `CHK("half", 1'b1, half_full_n)
    tend("offsets");
    pm.frst(1'b1, 1'b1);
    rchk("ser offsets", A_OFFS, 32'h03ff03ff);
    rchk("mode", A_STAT, st(15'h0, 1'b1, 1'b1));
    `CHK("ready in", 1'b0, full_or_input_ready)
    `CHK("ready out", 1'b1, empty_or_output_ready)
    `CHK("zero word", 9'h000, read_data)
    for (int i = 0; i < 28; i++) pm.sh(SER[i]);
    rchk("shifted", A_OFFS, 32'h00020003);
    pm.wr(9'h1a5);
    repeat (3) pm.tog;
    pm.w(3);
    `CHK("fall word", 9'h1a5, read_data)
    `CHK("out ready", 1'b0, empty_or_output_ready)
    pm.tog;
    pm.rd(1'b1);
    `CHK("ft rt ready", 1'b1, empty_or_output_ready)
    rchk("ft rt count", A_STAT, st(15'h1, 1'b1, 1'b1));
    tend("fall through");
    pm.oe(1'b1);
    pm.w(4);
    `CHK("oe off", 1'b0, read_data_oe)
    tend("output enable");
    test_done;
  end
endmodule
